// file: pkg/sfp_pkg.sv
// shared constants and types for the flash program and erase sequencer
package sfp_pkg;

	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned MEM_AW = 25;

	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] HDR_NARROW = 6'h20;
	localparam logic [5:0] HDR_WIDE = 6'h28;

	localparam int unsigned PAGE_LOG2 = 8;
	localparam int unsigned SECTOR_LOG2 = 12;
	localparam int unsigned BLOCK32_LOG2 = 15;
	localparam int unsigned BLOCK64_LOG2 = 16;
	localparam int unsigned PROT_MIN_LOG2 = 16;

	localparam int unsigned ST_WIP = 0;
	localparam int unsigned ST_WEL = 1;
	localparam int unsigned ST_BP_LO = 2;
	localparam int unsigned ST_QE = 9;
	localparam int unsigned ST_ADS = 11;

	localparam logic WEL_RESET = 1'b0;
	localparam logic ADS_RESET = 1'b0;
	localparam logic [7:0] LAST_INDEX = 8'hff;

	typedef enum logic [7:0] {
		OP_WRITE_ENABLE = 8'h06,
		OP_WRITE_DISABLE = 8'h04,
		OP_STATUS_LO = 8'h05,
		OP_STATUS_HI = 8'h35,
		OP_PAGE_WRITE = 8'h32,
		OP_PAGE_WRITE_WIDE = 8'h34,
		OP_SECTOR_WIPE = 8'h20,
		OP_SECTOR_WIPE_WIDE = 8'h21,
		OP_BLOCK32_WIPE = 8'h52,
		OP_BLOCK32_WIPE_WIDE = 8'h5c,
		OP_BLOCK64_WIPE = 8'hd8,
		OP_BLOCK64_WIPE_WIDE = 8'hdc,
		OP_CHIP_WIPE_A = 8'h60,
		OP_CHIP_WIPE_B = 8'hc7,
		OP_ENTER_WIDE = 8'hb7,
		OP_EXIT_WIDE = 8'he9
	} sfp_op_t;

	typedef enum logic [2:0] {
		WIPE_NONE = 3'b000,
		WIPE_SECTOR = 3'b001,
		WIPE_BLOCK32 = 3'b010,
		WIPE_BLOCK64 = 3'b011,
		WIPE_CHIP = 3'b100
	} sfp_wipe_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG = 2'b01,
		ST_TIME = 2'b10
	} sfp_state_t;

	typedef struct packed {
		logic write;
		sfp_wipe_t wipe;
		logic [31:0] addr;
		logic [7:0] data;
	} sfp_arr_req_t;

endpackage

// file: rtl/sfp_seq.sv
// program and erase command sequencer with its serial link front end
// Notes on behaviour
// - quad page write needs the quad-lane enable bit (status bit 9) set
// - over 256 data bytes: only the last 256 are programmed, same page
// - under 256 data bytes: other bytes of the page stay untouched
// - chip select must rise on a data byte boundary, else page write dropped
// - valid command starts self-timed cycle at select rise; busy 1 until done
// - status stays readable during a running cycle so busy can be polled
// - write-enable latch clears before each self-timed cycle completes
// - each program or erase needs the write-enable latch set beforehand
// - page write, sector and block erase refused on protected regions
// - sector erase from 20h (current width) or 21h (always 32-bit address)
// - any address in the sector selects it; low bits ignored
// - erase executes only if select rises right after the last address bit
// - 32KB block erase from 52h/5ch, any address in block, own time
// - 64KB block erase from d8h/dch, any address in block, longer time
// - chip erase 60h/c7h, no address, select rises after the eighth bit
// - chip erase ignored while any region is protected
// - b7h alone sets the address width bit (status bit 11) for 32-bit mode
// - reset gives 24-bit addressing; 32-bit mode only widens the address
// - dedicated wide opcodes always take a 32-bit address
// - page write data past the page end wraps to the page start
// - e9h clears the address width bit back to 24-bit addressing
`timescale 1ns/100ps
module sfp_seq #(
	parameter int unsigned PAGE_TIME_US = 600,
	parameter int unsigned SECTOR_WIPE_TIME_US = 45000,
	parameter int unsigned BLOCK32_WIPE_TIME_US = 150000,
	parameter int unsigned BLOCK64_WIPE_TIME_US = 200000,
	parameter int unsigned CHIP_WIPE_TIME_US = 60000000
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic so_out,
	output logic so_oe,
	input wire logic quad_lane_enable,
	input wire logic [4:0] block_protect,
	output logic write_in_progress,
	output logic write_enable_latch,
	output logic address_width_bit,
	output sfp_pkg::sfp_arr_req_t arr_req
);

	localparam logic [31:0] PAGE_CYC = 32'(PAGE_TIME_US * sfp_pkg::CLK_MHZ);
	localparam logic [31:0] SECTOR_CYC = 32'(SECTOR_WIPE_TIME_US * sfp_pkg::CLK_MHZ);
	localparam logic [31:0] BLOCK32_CYC = 32'(BLOCK32_WIPE_TIME_US * sfp_pkg::CLK_MHZ);
	localparam logic [31:0] BLOCK64_CYC = 32'(BLOCK64_WIPE_TIME_US * sfp_pkg::CLK_MHZ);
	localparam logic [31:0] CHIP_CYC = 32'(CHIP_WIPE_TIME_US * sfp_pkg::CLK_MHZ);

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic is_page(input logic [7:0] op);
		is_page = (op == sfp_pkg::OP_PAGE_WRITE) || (op == sfp_pkg::OP_PAGE_WRITE_WIDE);
	endfunction

	function automatic logic is_wide(input logic [7:0] op);
		is_wide = (op == sfp_pkg::OP_PAGE_WRITE_WIDE) || (op == sfp_pkg::OP_SECTOR_WIPE_WIDE) ||
			(op == sfp_pkg::OP_BLOCK32_WIPE_WIDE) || (op == sfp_pkg::OP_BLOCK64_WIPE_WIDE);
	endfunction

	function automatic sfp_pkg::sfp_wipe_t wipe_kind(input logic [7:0] op);
		case (op)
			sfp_pkg::OP_SECTOR_WIPE, sfp_pkg::OP_SECTOR_WIPE_WIDE: wipe_kind = sfp_pkg::WIPE_SECTOR;
			sfp_pkg::OP_BLOCK32_WIPE, sfp_pkg::OP_BLOCK32_WIPE_WIDE: wipe_kind = sfp_pkg::WIPE_BLOCK32;
			sfp_pkg::OP_BLOCK64_WIPE, sfp_pkg::OP_BLOCK64_WIPE_WIDE: wipe_kind = sfp_pkg::WIPE_BLOCK64;
			sfp_pkg::OP_CHIP_WIPE_A, sfp_pkg::OP_CHIP_WIPE_B: wipe_kind = sfp_pkg::WIPE_CHIP;
			default: wipe_kind = sfp_pkg::WIPE_NONE;
		endcase
	endfunction

	// protected span: 64KB doubled per step of bp[3:0], top end or bottom end by bp[4]
	function automatic logic prot_hit(input logic [4:0] bp, input logic [31:0] base,
		input int unsigned slog);
		logic [32:0] lo;
		logic [32:0] hi;
		logic [32:0] span;
		logic [32:0] top;
		lo = {1'b0, base} & ((33'h1 << sfp_pkg::MEM_AW) - 33'h1);
		hi = lo + (33'h1 << slog) - 33'h1;
		top = 33'h1 << sfp_pkg::MEM_AW;
		if (bp[3:0] == 4'h0) begin
			prot_hit = 1'b0;
		end else if (bp[3:0] >= 4'ha) begin
			prot_hit = 1'b1;
		end else begin
			span = 33'h1 << (sfp_pkg::PROT_MIN_LOG2 + 32'(bp[3:0]) - 1);
			prot_hit = bp[4] ? (lo < span) : (hi >= top - span);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link side, clocked by the host serial clock

	logic frame_rst;
	logic in_frame_reg;
	logic frame_tgl_reg;
	logic [5:0] hdr_cnt_reg;
	logic [7:0] op_reg;
	logic aw32_reg;
	logic [31:0] addr_reg;
	logic [7:0] idx_reg;
	logic [3:0] nib_reg;
	logic half_reg;
	logic any_reg;
	logic [7:0] buf_mem [0:255];
	logic [255:0] valid_reg;
	logic [9:0] lsync1_reg;
	logic [9:0] lsync2_reg;
	logic [2:0] obit_reg;
	logic [5:0] cnt_now;
	logic [5:0] hdr_lim;
	logic [7:0] op_now;
	logic hdr_done;
	logic page_ok;
	logic buf_wr;
	logic [15:0] stat_l;

	assign frame_rst = cs_n | ~resetn;
	assign cnt_now = in_frame_reg ? hdr_cnt_reg : 6'h00;
	assign hdr_lim = aw32_reg ? sfp_pkg::HDR_WIDE : sfp_pkg::HDR_NARROW;
	assign op_now = {op_reg[6:0], io_in[0]};
	assign hdr_done = (cnt_now >= sfp_pkg::OPC_BITS) && (cnt_now >= hdr_lim);
	assign page_ok = is_page(op_reg) && lsync2_reg[8] && !lsync2_reg[0];
	assign buf_wr = hdr_done && half_reg && page_ok;

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
		end
	end

	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			frame_tgl_reg <= 1'b0;
			hdr_cnt_reg <= 6'h00;
			op_reg <= 8'h00;
			aw32_reg <= 1'b0;
			addr_reg <= 32'h0000_0000;
			idx_reg <= 8'h00;
			nib_reg <= 4'h0;
			half_reg <= 1'b0;
			any_reg <= 1'b0;
		end else begin
			if (!in_frame_reg) begin
				frame_tgl_reg <= ~frame_tgl_reg;
				addr_reg <= 32'h0000_0000;
				any_reg <= 1'b0;
			end
			if (cnt_now < sfp_pkg::OPC_BITS) begin
				op_reg <= op_now;
			end
			if (cnt_now == sfp_pkg::OPC_BITS - 6'h01) begin
				aw32_reg <= is_wide(op_now) | lsync2_reg[9];
			end
			if (!hdr_done) begin
				hdr_cnt_reg <= cnt_now + 6'h01;
			end
			if ((cnt_now >= sfp_pkg::OPC_BITS) && (cnt_now < hdr_lim)) begin
				addr_reg <= {addr_reg[30:0], io_in[0]};
			end
			if ((cnt_now >= sfp_pkg::OPC_BITS) && (cnt_now == hdr_lim - 6'h01)) begin
				idx_reg <= {addr_reg[6:0], io_in[0]};
			end
			half_reg <= in_frame_reg && hdr_done && !half_reg;
			if (hdr_done && !half_reg) begin
				nib_reg <= io_in;
			end
			if (hdr_done && half_reg) begin
				idx_reg <= idx_reg + 8'h01;
				any_reg <= 1'b1;
			end
		end
	end

	// later bytes overwrite earlier ones, so the last 256 win
	always_ff @(posedge sclk) begin
		if (buf_wr) begin
			buf_mem[idx_reg] <= {nib_reg, io_in};
		end
	end

	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			valid_reg <= '0;
		end else if (!in_frame_reg) begin
			valid_reg <= '0;
		end else if (buf_wr) begin
			valid_reg[idx_reg] <= 1'b1;
		end
	end

	// status copy for the link: {ads, qe, bp, wel, 0, wip}
	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			lsync1_reg <= 10'h000;
			lsync2_reg <= 10'h000;
		end else begin
			lsync1_reg <= {address_width_bit, quad_lane_enable, block_protect,
				write_enable_latch, 1'b0, write_in_progress};
			lsync2_reg <= lsync1_reg;
		end
	end

	always_comb begin
		stat_l = 16'h0000;
		stat_l[sfp_pkg::ST_WIP] = lsync2_reg[0];
		stat_l[sfp_pkg::ST_WEL] = lsync2_reg[2];
		stat_l[sfp_pkg::ST_BP_LO +: 5] = lsync2_reg[7:3];
		stat_l[sfp_pkg::ST_QE] = lsync2_reg[8];
		stat_l[sfp_pkg::ST_ADS] = lsync2_reg[9];
	end

	// status shifted out msb first on falling edges, also while busy
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			so_out <= 1'b0;
			so_oe <= 1'b0;
			obit_reg <= 3'h0;
		end else if ((hdr_cnt_reg >= sfp_pkg::OPC_BITS) &&
			((op_reg == sfp_pkg::OP_STATUS_LO) || (op_reg == sfp_pkg::OP_STATUS_HI))) begin
			so_oe <= 1'b1;
			so_out <= (op_reg == sfp_pkg::OP_STATUS_LO) ? stat_l[3'h7 - obit_reg] :
				stat_l[4'(5'h0f - {2'b00, obit_reg})];
			obit_reg <= obit_reg + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// select release detection on the system clock

	logic [2:0] cs_s_reg;
	logic cs_lvl_reg;
	logic seen_tgl_reg;
	logic rise;
	logic new_frame;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cs_s_reg <= 3'b111;
			cs_lvl_reg <= 1'b1;
			seen_tgl_reg <= 1'b0;
		end else begin
			cs_s_reg <= {cs_s_reg[1:0], cs_n};
			if (cs_s_reg[1] == cs_s_reg[2]) begin
				cs_lvl_reg <= cs_s_reg[1];
			end
			if (rise) begin
				seen_tgl_reg <= frame_tgl_reg;
			end
		end
	end

	assign rise = cs_s_reg[1] && cs_s_reg[2] && !cs_lvl_reg;
	// link words are frozen while select is high, so they are read here directly
	assign new_frame = frame_tgl_reg != seen_tgl_reg;

	////////////////////////////////////////////////////////////////////////
	// command decision at select release

	sfp_pkg::sfp_wipe_t kind;
	logic [31:0] base;
	int unsigned slog;
	logic opc_only;
	logic addr_only;
	logic data_whole;
	logic may_run;
	logic start_prog;
	logic start_wipe;
	logic start_any;

	always_comb begin
		kind = wipe_kind(op_reg);
		base = aw32_reg ? addr_reg : {8'h00, addr_reg[23:0]};
		case (kind)
			sfp_pkg::WIPE_SECTOR: slog = sfp_pkg::SECTOR_LOG2;
			sfp_pkg::WIPE_BLOCK32: slog = sfp_pkg::BLOCK32_LOG2;
			sfp_pkg::WIPE_BLOCK64: slog = sfp_pkg::BLOCK64_LOG2;
			default: slog = sfp_pkg::PAGE_LOG2;
		endcase
		opc_only = hdr_cnt_reg == sfp_pkg::OPC_BITS;
		addr_only = (hdr_cnt_reg == hdr_lim) && !any_reg && !half_reg;
		data_whole = (hdr_cnt_reg == hdr_lim) && any_reg && !half_reg;
		may_run = rise && new_frame && write_enable_latch && !write_in_progress;
		start_prog = may_run && is_page(op_reg) && data_whole && quad_lane_enable &&
			!prot_hit(block_protect, base, slog);
		start_wipe = may_run && (kind != sfp_pkg::WIPE_NONE) && (kind != sfp_pkg::WIPE_CHIP) &&
			addr_only && !prot_hit(block_protect, base, slog);
		if (kind == sfp_pkg::WIPE_CHIP) begin
			start_wipe = may_run && opc_only && (block_protect[3:0] == 4'h0);
		end
		start_any = start_prog || start_wipe;
	end

	////////////////////////////////////////////////////////////////////////
	// status bits

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			write_enable_latch <= sfp_pkg::WEL_RESET;
		end else if (start_any) begin
			write_enable_latch <= 1'b0;
		end else if (rise && new_frame && opc_only) begin
			if (op_reg == sfp_pkg::OP_WRITE_ENABLE) begin
				write_enable_latch <= 1'b1;
			end else if (op_reg == sfp_pkg::OP_WRITE_DISABLE) begin
				write_enable_latch <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			address_width_bit <= sfp_pkg::ADS_RESET;
		end else if (rise && new_frame && opc_only) begin
			if (op_reg == sfp_pkg::OP_ENTER_WIDE) begin
				address_width_bit <= 1'b1;
			end else if (op_reg == sfp_pkg::OP_EXIT_WIDE) begin
				address_width_bit <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// self-timed cycle

	sfp_pkg::sfp_state_t state_reg;
	logic [31:0] tmr_reg;
	logic [8:0] walk_reg;
	logic [23:0] page_reg;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= sfp_pkg::ST_IDLE;
			tmr_reg <= 32'h0000_0000;
			walk_reg <= 9'h000;
			page_reg <= 24'h000000;
			write_in_progress <= 1'b0;
		end else begin
			if (tmr_reg != 32'h0000_0000) begin
				tmr_reg <= tmr_reg - 32'h0000_0001;
			end
			case (state_reg)
				sfp_pkg::ST_IDLE: begin
					walk_reg <= 9'h000;
					page_reg <= base[31:8];
					if (start_prog) begin
						state_reg <= sfp_pkg::ST_PROG;
						tmr_reg <= PAGE_CYC - 32'h0000_0001;
						write_in_progress <= 1'b1;
					end else if (start_wipe) begin
						state_reg <= sfp_pkg::ST_TIME;
						write_in_progress <= 1'b1;
						case (kind)
							sfp_pkg::WIPE_SECTOR: tmr_reg <= SECTOR_CYC - 32'h0000_0001;
							sfp_pkg::WIPE_BLOCK32: tmr_reg <= BLOCK32_CYC - 32'h0000_0001;
							sfp_pkg::WIPE_BLOCK64: tmr_reg <= BLOCK64_CYC - 32'h0000_0001;
							default: tmr_reg <= CHIP_CYC - 32'h0000_0001;
						endcase
					end
				end
				sfp_pkg::ST_PROG: begin
					walk_reg <= walk_reg + 9'h001;
					if (walk_reg[7:0] == sfp_pkg::LAST_INDEX) begin
						state_reg <= sfp_pkg::ST_TIME;
					end
				end
				sfp_pkg::ST_TIME: begin
					if (tmr_reg == 32'h0000_0000) begin
						state_reg <= sfp_pkg::ST_IDLE;
						write_in_progress <= 1'b0;
					end
				end
				default: begin
					state_reg <= sfp_pkg::ST_IDLE;
					write_in_progress <= 1'b0;
				end
			endcase
		end
	end

	// array requests: page bytes only where written, one erase pulse per cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			arr_req <= '0;
		end else begin
			arr_req.write <= (state_reg == sfp_pkg::ST_PROG) && valid_reg[walk_reg[7:0]];
			arr_req.data <= buf_mem[walk_reg[7:0]];
			arr_req.wipe <= sfp_pkg::WIPE_NONE;
			arr_req.addr <= {page_reg, walk_reg[7:0]};
			if ((state_reg == sfp_pkg::ST_IDLE) && start_wipe) begin
				arr_req.wipe <= kind;
				arr_req.addr <= base & ~((32'h1 << slog) - 32'h1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_cmd_frame;
		rise && new_frame;
	endsequence

	sequence s_opc(logic [7:0] code);
		s_cmd_frame ##0 (op_reg == code) && opc_only;
	endsequence

	a_busy_start: assert property (start_any |=> write_in_progress && !write_enable_latch)
		else $error("cycle start did not raise busy and clear the latch");
	a_refuse_idle: assert property (rise && !start_any && !write_in_progress |=> !write_in_progress)
		else $error("refused command raised busy");
	a_busy_reject: assert property (rise && write_in_progress |-> !start_any)
		else $error("command accepted while busy");
	a_chip_guard: assert property (s_cmd_frame ##0 (kind == sfp_pkg::WIPE_CHIP) &&
		(block_protect[3:0] != 4'h0) |-> !start_any)
		else $error("chip erase started with protection set");
	a_prog_qe: assert property (start_prog |-> quad_lane_enable && !half_reg && any_reg)
		else $error("page write started without quad enable or on a partial byte");
	a_ads_enter: assert property (s_opc(sfp_pkg::OP_ENTER_WIDE) |=> address_width_bit)
		else $error("enter wide address did not set the width bit");
	a_ads_exit: assert property (s_opc(sfp_pkg::OP_EXIT_WIDE) |=> !address_width_bit)
		else $error("exit wide address did not clear the width bit");
	a_sector_align: assert property (arr_req.wipe == sfp_pkg::WIPE_SECTOR |->
		arr_req.addr[11:0] == 12'h000)
		else $error("sector erase address not aligned");
	a_erase_shape: assert property (start_wipe && (kind != sfp_pkg::WIPE_CHIP) |->
		addr_only && write_enable_latch)
		else $error("erase started without exact address length or latch");
	a_prog_walk: assert property ($rose(write_in_progress) && (state_reg == sfp_pkg::ST_PROG) |->
		(state_reg == sfp_pkg::ST_PROG) [*8])
		else $error("page write walk cut short");

endmodule

// file: sim/sfp_host.sv
// host serial controller model that frames flash commands
`timescale 1ns/100ps
module sfp_host (
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_in,
	input wire logic so_out
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
	end
	////////////////////////////////////////////////////////////////
	// one rising edge, lanes set just after the falling edge
	task automatic bit4(input logic [3:0] v);
		io_in = v;
		#6 sclk = 1'b1;
		#6 sclk = 1'b0;
	endtask
	// opcode and address on lane 0, data high nibble first, then stray bits
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab,
		input int nb, input logic [7:0] d0, input int extra);
		logic [7:0] d;
		#3 cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) bit4({3'h0, op[i]});
		for (int i = ab - 1; i >= 0; i--) bit4({3'h0, a[i]});
		for (int k = 0; k < nb; k++) begin
			d = d0 + k[7:0] + k[15:8];
			bit4(d[7:4]);
			bit4(d[3:0]);
		end
		for (int i = 0; i < extra; i++) bit4(4'h1);
		#6 cs_n = 1'b1;
		io_in = ~io_in;
		#300;
	endtask
	// status byte read, lane 1 released to the device
	task automatic status(input logic [7:0] op, output logic [7:0] s);
		#3 cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) bit4({3'h0, op[i]});
		for (int i = 7; i >= 0; i--) begin
			io_in = {2'h0, so_out, 1'b0};
			#6 s[i] = so_out;
			sclk = 1'b1;
			#6 sclk = 1'b0;
		end
		#6 cs_n = 1'b1;
		#300;
	endtask
endmodule

// file: sim/sfp_seq_tb.sv
// self-checking bench for the program and erase sequencer
`timescale 1ns/100ps
module sfp_seq_tb;
	localparam int PG = 20 * sfp_pkg::CLK_MHZ;
	localparam int SE = 30 * sfp_pkg::CLK_MHZ;
	localparam int B32 = 40 * sfp_pkg::CLK_MHZ;
	localparam int B64 = 50 * sfp_pkg::CLK_MHZ;
	localparam int CE = 60 * sfp_pkg::CLK_MHZ;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic sclk, cs_n, so_out, so_oe;
	logic [3:0] io_in;
	logic quad_lane_enable = 1'b0;
	logic [4:0] block_protect = 5'h00;
	logic write_in_progress, write_enable_latch, address_width_bit;
	sfp_pkg::sfp_arr_req_t arr_req;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int wr_cnt = 0;
	int wp_cnt = 0;
	int busy_len = 0;
	logic [7:0] mem [256];
	logic [23:0] wr_hi;
	sfp_pkg::sfp_wipe_t wp_kind;
	logic [31:0] wp_addr;
	logic [7:0] st;
	logic oe_seen = 1'b0;

	sfp_seq #(.PAGE_TIME_US(20), .SECTOR_WIPE_TIME_US(30), .BLOCK32_WIPE_TIME_US(40),
		.BLOCK64_WIPE_TIME_US(50), .CHIP_WIPE_TIME_US(60)) u_sfp_seq (
		.mclk(mclk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
		.so_out(so_out), .so_oe(so_oe), .quad_lane_enable(quad_lane_enable),
		.block_protect(block_protect), .write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch), .address_width_bit(address_width_bit),
		.arr_req(arr_req));
	sfp_host u_sfp_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .so_out(so_out));

	always #20 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	// array request monitor and cycle ceiling
	always @(posedge mclk) begin
		cyc++;
		if (write_in_progress === 1'b1) busy_len++;
		if (so_oe === 1'b1) oe_seen = 1'b1;
		if (arr_req.write === 1'b1) begin
			wr_cnt++;
			mem[arr_req.addr[7:0]] = arr_req.data;
			wr_hi = arr_req.addr[31:8];
		end
		if (arr_req.wipe !== sfp_pkg::WIPE_NONE) begin
			wp_cnt++;
			wp_kind = arr_req.wipe;
			wp_addr = arr_req.addr;
		end
		if (cyc == 40000) begin
			n_errors++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic idle();
		for (int i = 0; i < 3000 && write_in_progress === 1'b1; i++) @(posedge mclk);
	endtask
	// write enable, then the command; accepted ones are waited out
	task automatic run(input logic [7:0] op, input logic [31:0] a, input int ab,
		input int nb, input int extra, input logic exp);
		u_sfp_host.frame(8'h06, 32'h0, 0, 0, 8'h00, 0);
		chk(write_enable_latch === 1'b1, "latch not set");
		wr_cnt = 0;
		wp_cnt = 0;
		busy_len = 0;
		u_sfp_host.frame(op, a, ab, nb, 8'h40, extra);
		chk(write_in_progress === exp, "busy at start");
		idle();
		chk(write_enable_latch === !exp, "latch after cycle");
		chk((wr_cnt + wp_cnt > 0) === exp, "array activity");
	endtask
	task automatic t_reset();
		chk(write_in_progress === 1'b0 && write_enable_latch === 1'b0, "reset state");
		chk(so_oe === 1'b0 && so_out === 1'b0, "reset lane");
		chk(address_width_bit === 1'b0 && arr_req === '0, "reset width");
	endtask
	task automatic t_page();
		@(posedge mclk) quad_lane_enable <= 1'b1;
		run(8'h32, 32'h0003fe, 24, 4, 0, 1'b1);
		chk(wr_cnt == 4 && wr_hi === 24'h000003, "short page");
		chk(mem[8'hfe] === 8'h40 && mem[8'h01] === 8'h43, "page wrap");
		chk(busy_len >= PG - 1 && busy_len <= PG + 1, "page time");
		run(8'h34, 32'h00000510, 32, 258, 0, 1'b1);
		chk(wr_cnt == 256 && wr_hi === 24'h000005, "long page");
		chk(mem[8'h10] === 8'h41 && mem[8'h11] === 8'h42, "last bytes kept");
	endtask
	task automatic t_refuse();
		u_sfp_host.frame(8'h32, 32'h0, 24, 2, 8'h00, 0);
		chk(write_in_progress === 1'b0, "no latch accepted");
		run(8'h32, 32'h000100, 24, 2, 1, 1'b0);
		run(8'h20, 32'h000100, 24, 0, 1, 1'b0);
		run(8'h60, 32'h0, 0, 0, 1, 1'b0);
		@(posedge mclk) quad_lane_enable <= 1'b0;
		run(8'h32, 32'h000100, 24, 2, 0, 1'b0);
		@(posedge mclk) quad_lane_enable <= 1'b1;
		block_protect <= 5'h01;
		run(8'h21, 32'h01ff1234, 32, 0, 0, 1'b0);
		run(8'hc7, 32'h0, 0, 0, 0, 1'b0);
		@(posedge mclk) block_protect <= 5'h00;
	endtask
	task automatic t_erase();
		logic [7:0] ops [8] = '{8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'h60, 8'hc7};
		int sh [5] = '{0, 12, 15, 16, 0};
		int tm [5] = '{PG, SE, B32, B64, CE};
		int k;
		for (int i = 0; i < 8; i++) begin
			k = (i < 6) ? i / 2 + 1 : 4;
			run(ops[i], 32'h00abcdef, (i >= 6) ? 0 : (i % 2) ? 32 : 24, 0, 0, 1'b1);
			chk(wp_kind === k[2:0], "wipe kind");
			chk(k == 4 || wp_addr === (32'h00abcdef & ~((32'h1 << sh[k]) - 1)), "wipe addr");
			chk(busy_len >= tm[k] - 1 && busy_len <= tm[k] + 1, "wipe time");
		end
	endtask
	task automatic t_wide();
		u_sfp_host.frame(8'hb7, 32'h0, 0, 0, 8'h00, 0);
		chk(address_width_bit === 1'b1, "wide mode on");
		run(8'h20, 32'h01ff1234, 32, 0, 0, 1'b1);
		chk(wp_addr === 32'h01ff1000, "wide sector addr");
		u_sfp_host.frame(8'he9, 32'h0, 0, 0, 8'h00, 0);
		chk(address_width_bit === 1'b0, "wide mode off");
	endtask
	task automatic t_busy();
		u_sfp_host.frame(8'h06, 32'h0, 0, 0, 8'h00, 0);
		wp_cnt = 0;
		u_sfp_host.frame(8'h20, 32'h0, 24, 0, 8'h00, 0);
		u_sfp_host.status(8'h05, st);
		chk(st[0] === 1'b1 && st[1] === 1'b0, "status while busy");
		chk(oe_seen === 1'b1 && so_oe === 1'b0, "lane one drive");
		u_sfp_host.frame(8'h06, 32'h0, 0, 0, 8'h00, 0);
		u_sfp_host.frame(8'h52, 32'h0, 24, 0, 8'h00, 0);
		idle();
		chk(wp_cnt == 1, "command taken while busy");
		u_sfp_host.status(8'h05, st);
		chk(st[0] === 1'b0, "status after cycle");
		u_sfp_host.status(8'h35, st);
		chk(st[1] === 1'b1 && st[3] === 1'b0, "status high byte");
		u_sfp_host.frame(8'h04, 32'h0, 0, 0, 8'h00, 0);
		chk(write_enable_latch === 1'b0, "write disable");
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge mclk);
		t_reset();
		t_page();
		t_refuse();
		t_erase();
		t_wide();
		t_busy();
		results();
	end
endmodule
